// ### design/arfc_top.v
/*
 * Control and result path of one converter result filter: control
 * register, filtered result register, ready flag and interrupt status.
 * Assumes converter results arrive on clk with a one-cycle valid strobe and
 * software uses a one-cycle read/write strobe port with read data a cycle
 * later.
 */
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "arfc_map.vh"
module arfc_top (
    input  wire                     clk,
    input  wire                     rst_b,
    input  wire [`ARFC_AW-1:0]      reg_addr,
    input  wire [`ARFC_DW-1:0]      reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [`ARFC_DW-1:0]      reg_rdata_ff,
    input  wire                     conv_valid,
    input  wire [4:0]               conv_channel,
    input  wire [`ARFC_SW-1:0]      conv_data,
    output reg                      result_ready_ff,
    output wire                     irq
);
    reg  [`ARFC_DW-1:0]  ctrl_ff;
    reg  [`ARFC_DW-1:0]  filtered_result_register_ff;
    reg  [`ARFC_ST_W-1:0] status_ff;
    reg  [`ARFC_ST_W-1:0] mask_ff;
    reg  [`ARFC_DW-1:0]  nxt_rdata;
    wire [`ARFC_ST_W-1:0] nxt_status;
    wire [`ARFC_ST_W-1:0] st_set;
    reg                  nxt_ready;
    wire                 filter_enable;
    wire [1:0]           filter_mode;
    wire [2:0]           oversample_ratio;
    wire                 filter_irq_enable;
    wire [4:0]           filter_channel_select;
    wire                 mode_legal;
    wire                 active;
    wire                 sample_en;
    wire                 cfg_write;
    wire [3:0]           log_n;
    wire [3:0]           shift;
    wire [`ARFC_ACW-1:0] sum;
    wire [`ARFC_ACW-1:0] shifted;
    wire                 done;
    wire                 rd_result;
    wire                 rd_status;

    // ratio code to log2 of the number of summed conversions
    function [3:0] ratio_log;
        input [2:0] code;
        begin
            case (code)
                `ARFC_RATIO_256: ratio_log = `ARFC_LOG_256;
                `ARFC_RATIO_128: ratio_log = `ARFC_LOG_128;
                // unclear codes run as 128x rather than guessing a format
                default:         ratio_log = `ARFC_LOG_128;
            endcase
        end
    endfunction

    function sel;
        input [`ARFC_AW-1:0] addr;
        input [`ARFC_AW-1:0] ofs;
        begin
            sel = (addr == ofs);
        end
    endfunction

    assign filter_enable         = ctrl_ff[`ARFC_BIT_EN];
    assign filter_mode           = ctrl_ff[`ARFC_MODE_HI:`ARFC_MODE_LO];
    assign oversample_ratio      = ctrl_ff[`ARFC_RATIO_HI:`ARFC_RATIO_LO];
    assign filter_irq_enable     = ctrl_ff[`ARFC_BIT_IE];
    assign filter_channel_select = ctrl_ff[`ARFC_CHAN_HI:`ARFC_CHAN_LO];

    // reserved mode 10 (and undefined 01) leave the filter idle
    assign mode_legal = (filter_mode == `ARFC_MODE_OVS) ||
                        (filter_mode == `ARFC_MODE_AVG);
    assign active     = filter_enable && mode_legal;
    assign sample_en  = active && conv_valid &&
                        (conv_channel == filter_channel_select);
    // reconfiguring mid-run would mix two settings in one sum
    assign cfg_write  = reg_wr && sel(reg_addr, `ARFC_OFS_CTRL);
    assign rd_result  = reg_rd && sel(reg_addr, `ARFC_OFS_RESULT);
    assign rd_status  = reg_rd && sel(reg_addr, `ARFC_OFS_STATUS);

    assign log_n = ratio_log(oversample_ratio);
    // averaging keeps 12 integer bits; oversampling keeps 4 fraction bits
    assign shift = (filter_mode == `ARFC_MODE_AVG) ? log_n :
                   (log_n - `ARFC_FRAC_BITS);
    assign shifted = sum >> shift;

    arfc_acc u_acc (
        .clk       (clk),
        .rst_b     (rst_b),
        .clr       (!active || cfg_write),
        .sample_en (sample_en),
        .sample    (conv_data),
        .log_n     (log_n),
        .sum_ff    (sum),
        .done_ff   (done)
    );

    always @(posedge clk) begin
        if (!rst_b) begin
            ctrl_ff <= `ARFC_CTRL_RESET;
            mask_ff <= `ARFC_ST_RESET;
        end else if (reg_wr) begin
            if (sel(reg_addr, `ARFC_OFS_CTRL)) begin
                ctrl_ff <= reg_wdata & `ARFC_CTRL_WMASK;
            end
            if (sel(reg_addr, `ARFC_OFS_MASK)) begin
                mask_ff <= reg_wdata[`ARFC_ST_W-1:0];
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            filtered_result_register_ff <= {`ARFC_DW{1'b0}};
        end else if (done && active) begin
            filtered_result_register_ff <= shifted[`ARFC_DW-1:0];
        end
    end

    // read clears the flag, but a new result in the same cycle wins
    always @* begin
        nxt_ready = result_ready_ff;
        if (rd_result) begin
            nxt_ready = 1'b0;
        end
        if (done) begin
            nxt_ready = 1'b1;
        end
        if (!filter_enable) begin
            nxt_ready = 1'b0;
        end
        // a write that clears the enable drops the flag on the same edge
        if (cfg_write && !reg_wdata[`ARFC_BIT_EN]) begin
            nxt_ready = 1'b0;
        end
    end

    // irq enable gates the events, not the irq pin itself
    assign st_set[`ARFC_ST_DONE] = done && active && filter_irq_enable;
    // overrun: a fresh result lands while the previous one is still unread
    assign st_set[`ARFC_ST_OVR]  = done && active && filter_irq_enable &&
                                   result_ready_ff && !rd_result;

    // a set in the same cycle as the clearing read wins, so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < `ARFC_ST_W; gi = gi + 1) begin : g_status
            assign nxt_status[gi] = st_set[gi] | (status_ff[gi] & ~rd_status);
        end
    endgenerate

    always @(posedge clk) begin
        if (!rst_b) begin
            result_ready_ff <= 1'b0;
            status_ff       <= `ARFC_ST_RESET;
        end else begin
            result_ready_ff <= nxt_ready;
            status_ff       <= nxt_status;
        end
    end

    always @* begin
        nxt_rdata = {`ARFC_DW{1'b0}};
        case (reg_addr)
            `ARFC_OFS_CTRL: begin
                nxt_rdata = ctrl_ff;
                nxt_rdata[`ARFC_BIT_RDY] = result_ready_ff;
            end
            `ARFC_OFS_RESULT: nxt_rdata = filtered_result_register_ff;
            `ARFC_OFS_STATUS: nxt_rdata[`ARFC_ST_W-1:0] = status_ff;
            `ARFC_OFS_MASK:   nxt_rdata[`ARFC_ST_W-1:0] = mask_ff;
            default:          nxt_rdata = {`ARFC_DW{1'b0}};
        endcase
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata_ff <= {`ARFC_DW{1'b0}};
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end else begin
            reg_rdata_ff <= {`ARFC_DW{1'b0}};
        end
    end

    assign irq = |(status_ff & mask_ff);
endmodule

// ### inc/arfc_map.vh
/*
 * Register map, field layout, reset values and filter codes of the converter
 * result filter control block.
 * Assumes it is included by bare name by every design file of the block.
 */
// How it works
// - writing the enable bit to one runs the filter on the chosen channel when the mode field is 00 or 11
// - enable at zero keeps the filter idle and forces the ready flag low
// - mode field 11 runs the filter as an averager
// - mode 00 oversamples; 10 is reserved and software must not write it
// - ratio code 011 sums 256 conversions; in mode 00 into a 16-bit 12.4 result, in mode 11 into a 12-bit average
`ifndef ARFC_MAP_VH
`define ARFC_MAP_VH

`define ARFC_AW           2
`define ARFC_DW           16
`define ARFC_SW           12
`define ARFC_ACW          20
`define ARFC_CW           9

`define ARFC_OFS_CTRL     2'h0
`define ARFC_OFS_RESULT   2'h1
`define ARFC_OFS_STATUS   2'h2
`define ARFC_OFS_MASK     2'h3

`define ARFC_CTRL_RESET   16'h0000
`define ARFC_BIT_EN       15
`define ARFC_MODE_HI      14
`define ARFC_MODE_LO      13
`define ARFC_RATIO_HI     12
`define ARFC_RATIO_LO     10
`define ARFC_BIT_IE       9
`define ARFC_BIT_RDY      8
`define ARFC_CHAN_HI      4
`define ARFC_CHAN_LO      0
`define ARFC_CTRL_WMASK   16'hFE1F

`define ARFC_MODE_OVS     2'h0
`define ARFC_MODE_AVG     2'h3
`define ARFC_RATIO_128    3'h7
`define ARFC_RATIO_256    3'h3
`define ARFC_LOG_128      4'h7
`define ARFC_LOG_256      4'h8
`define ARFC_FRAC_BITS    4'h4

`define ARFC_ST_DONE      0
`define ARFC_ST_OVR       1
`define ARFC_ST_W         2
`define ARFC_ST_RESET     2'h0

`endif

// ### design/arfc_acc.v
/*
 * Accumulator for the result filter: sums 2^log_n samples, then presents
 * the total from a register with a one-cycle done pulse.
 * Assumes samples arrive on the same clock; clr restarts a partial sum.
 */
`timescale 1ns/1ps
`include "arfc_map.vh"
module arfc_acc (
    input  wire                     clk,
    input  wire                     rst_b,
    input  wire                     clr,
    input  wire                     sample_en,
    input  wire [`ARFC_SW-1:0]      sample,
    input  wire [3:0]               log_n,
    output reg  [`ARFC_ACW-1:0]     sum_ff,
    output reg                      done_ff
);
    reg  [`ARFC_CW-1:0]  cnt_ff;
    reg  [`ARFC_ACW-1:0] acc_ff;
    wire [`ARFC_CW-1:0]  target;
    wire [`ARFC_CW-1:0]  nxt_cnt;
    wire [`ARFC_ACW-1:0] nxt_acc;
    wire                 last;

    assign target  = {{(`ARFC_CW-1){1'b0}}, 1'b1} << log_n;
    assign nxt_cnt = cnt_ff + {{(`ARFC_CW-1){1'b0}}, 1'b1};
    assign nxt_acc = acc_ff + {{(`ARFC_ACW-`ARFC_SW){1'b0}}, sample};
    assign last    = (nxt_cnt == target);

    always @(posedge clk) begin
        if (!rst_b || clr) begin
            cnt_ff  <= {`ARFC_CW{1'b0}};
            acc_ff  <= {`ARFC_ACW{1'b0}};
            done_ff <= 1'b0;
            if (!rst_b) begin
                sum_ff <= {`ARFC_ACW{1'b0}};
            end
        end else begin
            done_ff <= 1'b0;
            if (sample_en) begin
                if (last) begin
                    sum_ff  <= nxt_acc;
                    acc_ff  <= {`ARFC_ACW{1'b0}};
                    cnt_ff  <= {`ARFC_CW{1'b0}};
                    done_ff <= 1'b1;
                end else begin
                    acc_ff <= nxt_acc;
                    cnt_ff <= nxt_cnt;
                end
            end
        end
    end
endmodule

// ### testbench/arfc_top_assertions.sv
/* Port checker for arfc_top: read-back, ready flag, interrupt.
   Assumes binding to arfc_top; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module arfc_chk (
    input logic        clk,
    input logic        rst_b,
    input logic [1:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [15:0] reg_rdata_ff,
    input logic        conv_valid,
    input logic        result_ready_ff,
    input logic        irq
);
    logic [15:0] ctl_ff;
    logic [1:0]  msk_ff;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    // shadows built from the bus alone, so a stuck register shows up
    always_ff @(posedge clk) begin
        if (!rst_b) ctl_ff <= 16'h0000;
        else if (reg_wr && reg_addr == 2'h0) ctl_ff <= reg_wdata & 16'hFE1F;
        if (!rst_b) msk_ff <= 2'h0;
        else if (reg_wr && reg_addr == 2'h3) msk_ff <= reg_wdata[1:0];
    end
    sequence s_result_read;
        reg_rd && reg_addr == 2'h1;
    endsequence
    sequence s_conv_quiet;
        !conv_valid && !$past(conv_valid) && !$past(conv_valid, 2) && !$past(conv_valid, 3);
    endsequence
    a_ready_needs_enable: assert property (result_ready_ff |-> ctl_ff[15])
        else $error("ready while disabled");
    a_ready_mode_ok: assert property ($rose(result_ready_ff) |-> ctl_ff[14:13] != 2'h1 && ctl_ff[14:13] != 2'h2)
        else $error("ready in reserved mode");
    a_ready_read_clear: assert property (s_result_read ##0 s_conv_quiet |=> !result_ready_ff)
        else $error("ready kept after result read");
    a_ready_holds: assert property (result_ready_ff && !reg_rd && !reg_wr |=> result_ready_ff)
        else $error("ready dropped alone");
    a_ctrl_readback: assert property (reg_rd && reg_addr == 2'h0 |=> (reg_rdata_ff & 16'hFEFF) == $past(ctl_ff))
        else $error("control read-back wrong");
    a_mask_readback: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata_ff == {14'h0, $past(msk_ff)})
        else $error("mask read-back wrong");
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata_ff == 16'h0000)
        else $error("read data outside read cycle");
    a_irq_needs_mask: assert property (irq |-> msk_ff != 2'h0)
        else $error("irq with all masked");
endmodule
bind arfc_top arfc_chk u_chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .conv_valid(conv_valid), .result_ready_ff(result_ready_ff), .irq(irq));

// ### testbench/arfc_conv_model.sv
/* Converter result path model feeding arfc_top.
   Assumes burst is called from one process at a time. */
`timescale 1ns/1ps
module arfc_conv_model (
    input  logic        clk,
    output logic        conv_valid,
    output logic [4:0]  conv_channel,
    output logic [11:0] conv_data
);
    initial begin
        conv_valid = 1'b0;
        conv_channel = 5'h00;
        conv_data = 12'h000;
    end
    // a stray other-channel sample every eighth slot must be ignored
    task automatic burst(input int n, input logic [4:0] ch, output int sum);
        logic [11:0] d;
        sum = 0;
        for (int i = 0; i < n; i++) begin
            d = 12'($urandom);
            @(posedge clk);
            conv_valid <= 1'b1;
            conv_data <= d;
            conv_channel <= (i % 8 == 5) ? ~ch : ch;
            if (i % 8 == 5) begin
                @(posedge clk);
                conv_channel <= ch;
            end
            sum += d;
            @(posedge clk);
            conv_valid <= 1'b0;
            conv_data <= ~d;
            repeat ($urandom % 3) @(posedge clk);
        end
    endtask
endmodule

// ### testbench/arfc_top_bench.sv
/* Self-checking bench for arfc_top.
   Assumes the converter model and bound checker are compiled with it. */
`timescale 1ns/1ps
module arfc_top_bench;
    logic        clk, rst_b, reg_wr, reg_rd, conv_valid, result_ready_ff, irq;
    logic [1:0]  reg_addr;
    logic [4:0]  conv_channel, ch;
    logic [11:0] conv_data;
    logic [15:0] reg_wdata, reg_rdata_ff, w;
    int          miscompares = 0, cmp_count = 0, cycles = 0, sum, seed;
    arfc_top dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_data(conv_data),
        .result_ready_ff(result_ready_ff), .irq(irq));
    arfc_conv_model src (.clk(clk), .conv_valid(conv_valid), .conv_channel(conv_channel),
        .conv_data(conv_data));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkf(input string what, input logic exp, input logic got);
        chk(what, {15'h0, exp}, {15'h0, got});
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [1:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata_ff);
    endtask
    // expected result is the plain sum shifted by the format's drop count
    task automatic run(input logic [15:0] c, input int n, input int sh);
        logic ok;
        ok = c[15] && c[14:13] != 2'h1 && c[14:13] != 2'h2;
        wr(2'h0, c);
        src.burst(n, c[4:0], sum);
        for (int k = 0; k < 8 && result_ready_ff !== 1'b1; k++)
            @(posedge clk);
        @(posedge clk);
        #1 chkf("ready", ok, result_ready_ff);
        chkf("irq", ok && c[9], irq);
        if (ok) begin
            rc(2'h2, {15'h0, c[9]}, "status");
            chkf("irq after status read", 1'b0, irq);
            rc(2'h1, 16'(sum >> sh), "result");
            chkf("ready after read", 1'b0, result_ready_ff);
        end
    endtask
    initial begin
        {rst_b, reg_wr, reg_rd} = 3'b000;
        reg_addr = 2'h0;
        reg_wdata = 16'h0000;
        seed = $urandom(47);
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 4; a++)
            rc(2'(a), 16'h0000, "reset value");
        w = 16'($urandom);
        wr(2'h3, w);
        rc(2'h3, w & 16'h0003, "mask");
        wr(2'h3, 16'h0001);
        w = 16'($urandom) & 16'h7FFF;
        wr(2'h0, w);
        rc(2'h0, w & 16'hFE1F, "control");
        ch = 5'($urandom);
        run(16'h9E00 | ch, 128, 3);
        run(16'h8C00 | ch, 256, 4);
        run(16'hFC00 | ch, 128, 7);
        run(16'hEE00 | ch, 256, 8);
        run(16'h8200 | ch, 128, 3);
        run(16'hDC00 | ch, 128, 0);
        run(16'hBC00 | ch, 128, 0);
        run(16'h1C00 | ch, 128, 0);
        wr(2'h0, 16'h9E00 | ch);
        src.burst(128, ch, sum);
        src.burst(128, ch, sum);
        repeat (4) @(posedge clk);
        #1 chkf("ready before disable", 1'b1, result_ready_ff);
        rc(2'h2, 16'h0003, "status overrun");
        wr(2'h0, 16'h1C00 | ch);
        @(posedge clk);
        #1 chkf("ready after disable", 1'b0, result_ready_ff);
        conclude();
    end
endmodule
